/* common/pmic_cfg_pkg.sv */
// Constants, field layouts and state codes for the start-up configuration block
package pmic_cfg_pkg;
	// Clock and derived time bases
	localparam int CLK_HZ         = 50_000_000;
	localparam int CLK_PERIOD_NS  = 20;
	localparam int CYC_PER_US     = CLK_HZ / 1_000_000;
	localparam int LONG_PRESS_MS  = 4000;
	localparam int LONG_PRESS_CYC = LONG_PRESS_MS * 1000 * CYC_PER_US;
	localparam int RAMP_FAST_NS   = 2000;
	localparam int RAMP_SLOW_NS   = 4000;
	localparam int RAMP_FAST_CYC  = RAMP_FAST_NS / CLK_PERIOD_NS;
	localparam int RAMP_SLOW_CYC  = RAMP_SLOW_NS / CLK_PERIOD_NS;
	localparam int SLOT_FAST_US   = 500;
	localparam int SLOT_SLOW_US   = 2000;
	localparam int SLOT_FAST_CYC  = SLOT_FAST_US * CYC_PER_US;
	localparam int SLOT_SLOW_CYC  = SLOT_SLOW_US * CYC_PER_US;
	localparam int RST_DELAY_US   = 2000;
	localparam int RST_DELAY_CYC  = RST_DELAY_US * CYC_PER_US;

	// Target address configuration register layout
	localparam int             ADDR_CFG_W     = 8;
	localparam int             ADDR_KEEP_BIT  = 7;
	localparam int             ADDR_CODE_W    = 3;
	localparam logic [7:0]     ADDR_RW_MASK   = 8'h87;
	localparam logic [7:0]     ADDR_FIXED_SET = 8'h08;
	localparam logic [7:0]     ADDR_CFG_RST   = 8'h08;
	localparam logic [3:0]     ADDR_HIGH_BITS = 4'h1;
	localparam logic [6:0]     FACTORY_ADDR   = 7'h08;

	// Power-request pin modes
	localparam logic           PIN_MODE_LEVEL = 1'b0;
	localparam logic           PIN_MODE_EDGE  = 1'b1;

	// Start-up slot code width (four-bit codes, positions 1..15, zero means not sequenced)
	localparam int             SLOT_CODE_W    = 4;

	typedef enum logic [2:0] {
		ST_COLD = 3'b000,
		ST_OFF  = 3'b001,
		ST_LOAD = 3'b010,
		ST_SEQ  = 3'b011,
		ST_RSTW = 3'b100,
		ST_ON   = 3'b101
	} pwr_state_e;
endpackage : pmic_cfg_pkg

/* rtl/pin_sync.sv */
// Two-flop synchroniser for the power-request pin
module pin_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Pin in, synchronised level out
	input  wire logic pinIn,
	output wire logic pinOut
);
	logic stage1_ff;
	logic stage2_ff;
	logic nxt_stage1;
	logic nxt_stage2;

	always_comb begin
		nxt_stage1 = pinIn;
		nxt_stage2 = stage1_ff;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stage1_ff <= 1'b0;
			stage2_ff <= 1'b0;
		end else begin
			stage1_ff <= nxt_stage1;
			stage2_ff <= nxt_stage2;
		end
	end

	assign pinOut = stage2_ff;
endmodule : pin_sync

/* rtl/pmic_otp_config_startup.sv */
// Fuse-to-shadow loader, power-request pin control and start-up sequencer
//
// What this block does
// - With pin mode 0 a high power-request level turns the device on and a low level turns it off.
// - With pin mode 1 a falling edge on the power-request pin turns the device on.
// - With pin mode 1 the device turns off once the pin has stayed low for 4.0 s.
// - The seven-bit target address always lies between 0x08 and 0x0F.
// - Address bit 3 is fixed at one and the low three bits map codes 000..111 to 0x08..0x0F.
// - A completed write to the address register changes the answering address at once.
// - With bit 7 of the address register set the device keeps answering at 0x08.
// - The ramp select gives one buck step every 2.0 us (0) or every 4.0 us (1).
// - At cold start the fuses are copied to the shadow registers once the supply is above threshold.
// - Every turn-on reloads the shadow registers from the fuses before any regulator starts.
// - Regulator voltages and start-up slots come from the shadow registers, not the fuses.
// - Slot codes place regulators at positions 1..15, spaced 0.5 ms or 2.0 ms by the spacing select.
// - A regulator with slot code zero stays off in the sequence and may be enabled by software after it.
// - The processor reset output is released 2.0 ms after the last used slot.
module pmic_otp_config_startup
	import pmic_cfg_pkg::*;
#(
	parameter int NREG           = 8,
	parameter int VOLT_W         = 5,
	parameter int LONG_PRESS_CYC = pmic_cfg_pkg::LONG_PRESS_CYC,
	parameter int SLOT_FAST_CYC  = pmic_cfg_pkg::SLOT_FAST_CYC,
	parameter int SLOT_SLOW_CYC  = pmic_cfg_pkg::SLOT_SLOW_CYC,
	parameter int RST_DELAY_CYC  = pmic_cfg_pkg::RST_DELAY_CYC
) (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// Pin and supply monitor
	input  wire logic                          powerRequestPin,
	input  wire logic                          supplyAboveUv,
	// Fuse contents
	input  wire logic                          fusePinMode,
	input  wire logic                          fuseRampSel,
	input  wire logic                          fuseSlotSpacing,
	input  wire logic [ADDR_CFG_W-1:0]         fuseAddrCfg,
	input  wire logic [NREG*SLOT_CODE_W-1:0]   fuseSlotCode,
	input  wire logic [NREG*VOLT_W-1:0]        fuseVolt,
	// Address register write from the serial target
	input  wire logic                          addrCfgWrDone,
	input  wire logic [ADDR_CFG_W-1:0]         addrCfgWrData,
	// Software regulator enables
	input  wire logic [NREG-1:0]               swRegEnable,
	// Address register and active address
	output wire logic [ADDR_CFG_W-1:0]         addrCfgRdData,
	output wire logic [6:0]                    targetAddr,
	// Regulator control
	output wire logic                          deviceOn,
	output wire logic                          seqDone,
	output wire logic [NREG-1:0]               regEnable,
	output wire logic [NREG*VOLT_W-1:0]        regVoltage,
	output wire logic                          rampStep,
	// Processor reset, open drain
	output wire logic                          procResetOut,
	output wire logic                          procResetOe_n
);
	localparam int LPW = $clog2(LONG_PRESS_CYC + 1);
	localparam int SCW = $clog2(SLOT_SLOW_CYC + 1);
	localparam int RCW = $clog2(RST_DELAY_CYC + 1);
	localparam int RPW = $clog2(RAMP_SLOW_CYC + 1);
	localparam int CW  = SLOT_CODE_W;

	function automatic logic [CW-1:0] lastUsedSlot(input logic [NREG*CW-1:0] codes);
		logic [CW-1:0] m;
		m = '0;
		for (int i = 0; i < NREG; i++) begin
			if (codes[i*CW +: CW] > m) begin
				m = codes[i*CW +: CW];
			end
		end
		return m;
	endfunction : lastUsedSlot

	function automatic logic [NREG-1:0] slotHits(input logic [NREG*CW-1:0] codes, input logic [CW-1:0] slot);
		logic [NREG-1:0] h;
		h = '0;
		for (int i = 0; i < NREG; i++) begin
			h[i] = (codes[i*CW +: CW] == slot);
		end
		return h;
	endfunction : slotHits

	function automatic logic [6:0] addrFromCfg(input logic [ADDR_CFG_W-1:0] cfg);
		return cfg[ADDR_KEEP_BIT] ? FACTORY_ADDR : {ADDR_HIGH_BITS, cfg[ADDR_CODE_W-1:0]};
	endfunction : addrFromCfg

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation, edge and long-press detection
	logic           pinSync;
	logic           pinPrev_ff;
	logic           nxt_pinPrev;
	logic [LPW-1:0] lowCnt_ff;
	logic [LPW-1:0] nxt_lowCnt;
	logic           fallEdge;
	logic           longPress;
	pwr_state_e     state_ff;
	logic           shadowPinMode_ff;

	pin_sync uPinSync (
		.clk    (clk),
		.rst_n  (rst_n),
		.pinIn  (powerRequestPin),
		.pinOut (pinSync)
	);

	always_comb begin
		nxt_pinPrev = pinSync;
		nxt_lowCnt  = lowCnt_ff;
		if (pinSync || shadowPinMode_ff == PIN_MODE_LEVEL) begin
			nxt_lowCnt = '0;
		end else if (!longPress) begin
			nxt_lowCnt = lowCnt_ff + 1'b1;
		end
		fallEdge  = pinPrev_ff && !pinSync;
		longPress = !pinSync && (lowCnt_ff == LPW'(LONG_PRESS_CYC - 1));
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pinPrev_ff <= 1'b0;
			lowCnt_ff  <= '0;
		end else begin
			pinPrev_ff <= nxt_pinPrev;
			lowCnt_ff  <= nxt_lowCnt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shadow configuration and target address
	logic                  shadowRamp_ff;
	logic                  shadowSpacing_ff;
	logic [NREG*CW-1:0]    shadowSlot_ff;
	logic [NREG*VOLT_W-1:0] shadowVolt_ff;
	logic [ADDR_CFG_W-1:0] addrCfg_ff;
	logic [6:0]            targetAddr_ff;
	logic                  nxt_shadowPinMode;
	logic                  nxt_shadowRamp;
	logic                  nxt_shadowSpacing;
	logic [NREG*CW-1:0]    nxt_shadowSlot;
	logic [NREG*VOLT_W-1:0] nxt_shadowVolt;
	logic [ADDR_CFG_W-1:0] nxt_addrCfg;
	logic [6:0]            nxt_targetAddr;
	logic                  loadNow;

	always_comb begin
		// Cold-start copy and per-turn-on reload share one path
		loadNow           = (state_ff == ST_COLD && supplyAboveUv) || state_ff == ST_LOAD;
		nxt_shadowPinMode = shadowPinMode_ff;
		nxt_shadowRamp    = shadowRamp_ff;
		nxt_shadowSpacing = shadowSpacing_ff;
		nxt_shadowSlot    = shadowSlot_ff;
		nxt_shadowVolt    = shadowVolt_ff;
		nxt_addrCfg       = addrCfg_ff;
		if (loadNow) begin
			nxt_shadowPinMode = fusePinMode;
			nxt_shadowRamp    = fuseRampSel;
			nxt_shadowSpacing = fuseSlotSpacing;
			nxt_shadowSlot    = fuseSlotCode;
			nxt_shadowVolt    = fuseVolt;
			nxt_addrCfg       = (fuseAddrCfg & ADDR_RW_MASK) | ADDR_FIXED_SET;
		end
		// A finished write beats a same-cycle reload: it is the newer intent
		if (addrCfgWrDone) begin
			nxt_addrCfg = (addrCfgWrData & ADDR_RW_MASK) | ADDR_FIXED_SET;
		end
		nxt_targetAddr = addrFromCfg(nxt_addrCfg);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shadowPinMode_ff <= PIN_MODE_LEVEL;
			shadowRamp_ff    <= 1'b0;
			shadowSpacing_ff <= 1'b0;
			shadowSlot_ff    <= '0;
			shadowVolt_ff    <= '0;
			addrCfg_ff       <= ADDR_CFG_RST;
			targetAddr_ff    <= FACTORY_ADDR;
		end else begin
			shadowPinMode_ff <= nxt_shadowPinMode;
			shadowRamp_ff    <= nxt_shadowRamp;
			shadowSpacing_ff <= nxt_shadowSpacing;
			shadowSlot_ff    <= nxt_shadowSlot;
			shadowVolt_ff    <= nxt_shadowVolt;
			addrCfg_ff       <= nxt_addrCfg;
			targetAddr_ff    <= nxt_targetAddr;
		end
	end

	a_addr_range: assert property (@(posedge clk) disable iff (!rst_n)
		targetAddr_ff[6:3] == ADDR_HIGH_BITS) else $error("target address left 0x08..0x0F");
	a_addr_update: assert property (@(posedge clk) disable iff (!rst_n)
		addrCfgWrDone && !addrCfgWrData[ADDR_KEEP_BIT]
		|=> targetAddr_ff == {ADDR_HIGH_BITS, $past(addrCfgWrData[ADDR_CODE_W-1:0])})
		else $error("address not taken right after write");
	a_keep_factory: assert property (@(posedge clk) disable iff (!rst_n)
		addrCfgWrDone && addrCfgWrData[ADDR_KEEP_BIT] |=> targetAddr_ff == FACTORY_ADDR && addrCfg_ff[ADDR_KEEP_BIT])
		else $error("factory address not kept");

	////////////////////////////////////////////////////////////////////////////////
	// Turn-on, start-up sequence and processor reset
	pwr_state_e     nxt_state;
	logic [CW-1:0]  slot_ff;
	logic [CW-1:0]  nxt_slot;
	logic [SCW-1:0] slotCnt_ff;
	logic [SCW-1:0] nxt_slotCnt;
	logic [RCW-1:0] rstCnt_ff;
	logic [RCW-1:0] nxt_rstCnt;
	logic [NREG-1:0] seqEnable_ff;
	logic [NREG-1:0] nxt_seqEnable;
	logic [NREG-1:0] regEnable_ff;
	logic [NREG-1:0] nxt_regEnable;
	logic           seqDone_ff;
	logic           nxt_seqDone;
	logic           deviceOn_ff;
	logic           nxt_deviceOn;
	logic           resetOe_n_ff;
	logic           nxt_resetOe_n;
	logic           turnOn;
	logic           turnOff;
	logic           slotTick;
	logic [CW-1:0]  lastSlot;
	logic [CW-1:0]  slotNext;

	always_comb begin
		turnOn   = (shadowPinMode_ff == PIN_MODE_EDGE) ? fallEdge : pinSync;
		turnOff  = (shadowPinMode_ff == PIN_MODE_EDGE) ? longPress : !pinSync;
		slotTick = slotCnt_ff == (shadowSpacing_ff ? SCW'(SLOT_SLOW_CYC - 1) : SCW'(SLOT_FAST_CYC - 1));
		lastSlot = lastUsedSlot(shadowSlot_ff);
		slotNext = slot_ff + 1'b1;
		nxt_state     = state_ff;
		nxt_slot      = slot_ff;
		nxt_slotCnt   = slotCnt_ff;
		nxt_rstCnt    = rstCnt_ff;
		nxt_seqEnable = seqEnable_ff;
		nxt_seqDone   = seqDone_ff;
		nxt_resetOe_n = resetOe_n_ff;
		case (state_ff)
			ST_COLD: begin
				if (supplyAboveUv) begin
					nxt_state = ST_OFF;
				end
			end
			ST_OFF: begin
				if (turnOn) begin
					nxt_state = ST_LOAD;
				end
			end
			ST_LOAD: begin
				// Nothing is enabled here: the reload lands before the first slot
				nxt_slot      = '0;
				nxt_slotCnt   = '0;
				nxt_rstCnt    = '0;
				nxt_seqEnable = '0;
				nxt_state     = ST_SEQ;
			end
			ST_SEQ: begin
				if (lastSlot == '0) begin
					nxt_state = ST_RSTW;
				end else if (slotTick) begin
					nxt_slotCnt   = '0;
					nxt_slot      = slotNext;
					nxt_seqEnable = seqEnable_ff | slotHits(shadowSlot_ff, slotNext);
					if (slotNext >= lastSlot) begin
						nxt_state = ST_RSTW;
					end
				end else begin
					nxt_slotCnt = slotCnt_ff + 1'b1;
				end
			end
			ST_RSTW: begin
				if (rstCnt_ff == RCW'(RST_DELAY_CYC - 1)) begin
					nxt_state     = ST_ON;
					nxt_resetOe_n = 1'b1;
					nxt_seqDone   = 1'b1;
				end else begin
					nxt_rstCnt = rstCnt_ff + 1'b1;
				end
			end
			ST_ON: begin
				nxt_state = ST_ON;
			end
			default: begin
				nxt_state = ST_COLD;
			end
		endcase
		if (turnOff && (state_ff == ST_SEQ || state_ff == ST_RSTW || state_ff == ST_ON)) begin
			nxt_state     = ST_OFF;
			nxt_seqEnable = '0;
			nxt_seqDone   = 1'b0;
			nxt_resetOe_n = 1'b0;
		end
		// Software enables only count once the sequence is over
		nxt_regEnable = nxt_seqEnable | (nxt_seqDone ? swRegEnable : '0);
		nxt_deviceOn  = !(nxt_state == ST_COLD || nxt_state == ST_OFF);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff     <= ST_COLD;
			slot_ff      <= '0;
			slotCnt_ff   <= '0;
			rstCnt_ff    <= '0;
			seqEnable_ff <= '0;
			regEnable_ff <= '0;
			seqDone_ff   <= 1'b0;
			deviceOn_ff  <= 1'b0;
			resetOe_n_ff <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			slot_ff      <= nxt_slot;
			slotCnt_ff   <= nxt_slotCnt;
			rstCnt_ff    <= nxt_rstCnt;
			seqEnable_ff <= nxt_seqEnable;
			regEnable_ff <= nxt_regEnable;
			seqDone_ff   <= nxt_seqDone;
			deviceOn_ff  <= nxt_deviceOn;
			resetOe_n_ff <= nxt_resetOe_n;
		end
	end

	a_level_on: assert property (@(posedge clk) disable iff (!rst_n)
		state_ff == ST_OFF && shadowPinMode_ff == PIN_MODE_LEVEL && pinSync |=> state_ff == ST_LOAD)
		else $error("high level did not start turn-on");
	a_level_off: assert property (@(posedge clk) disable iff (!rst_n)
		deviceOn_ff && state_ff != ST_LOAD && shadowPinMode_ff == PIN_MODE_LEVEL && !pinSync
		|=> !deviceOn_ff && procResetOe_n == 1'b0) else $error("low level did not turn off");
	a_edge_on: assert property (@(posedge clk) disable iff (!rst_n)
		state_ff == ST_OFF && shadowPinMode_ff == PIN_MODE_EDGE
		|=> (state_ff == ST_LOAD) == $past(pinPrev_ff && !pinSync)) else $error("edge turn-on mismatch");
	// Covers the sequence as well: a short press mid-sequence must not cut it
	a_no_early_off: assert property (@(posedge clk) disable iff (!rst_n)
		(state_ff == ST_SEQ || state_ff == ST_RSTW || state_ff == ST_ON) && shadowPinMode_ff == PIN_MODE_EDGE
		&& lowCnt_ff < LPW'(LONG_PRESS_CYC - 1)
		|=> state_ff != ST_OFF) else $error("turned off before long press");
	a_cold_load: assert property (@(posedge clk) disable iff (!rst_n)
		state_ff == ST_COLD && supplyAboveUv
		|=> state_ff == ST_OFF && shadowSlot_ff == $past(fuseSlotCode) && shadowVolt_ff == $past(fuseVolt))
		else $error("cold-start copy missing");
	a_reload_first: assert property (@(posedge clk) disable iff (!rst_n)
		state_ff == ST_OFF ##1 state_ff == ST_LOAD
		|=> regEnable_ff == '0 && shadowSlot_ff == $past(fuseSlotCode)) else $error("no reload before sequence");
	a_slot_zero: assert property (@(posedge clk) disable iff (!rst_n)
		!seqDone_ff |-> (regEnable_ff & slotHits(shadowSlot_ff, '0)) == '0)
		else $error("slot-zero regulator on in sequence");
	a_reset_release: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(resetOe_n_ff) |-> $past(state_ff) == ST_RSTW && $past(rstCnt_ff) == RCW'(RST_DELAY_CYC - 1))
		else $error("reset released at wrong time");
	a_slot_step: assert property (@(posedge clk) disable iff (!rst_n)
		state_ff == ST_SEQ && lastSlot != '0 && slotTick && !turnOff |=> slot_ff == $past(slotNext) && slotCnt_ff == '0)
		else $error("slot did not advance");

	////////////////////////////////////////////////////////////////////////////////
	// Buck soft-start step timer
	logic [RPW-1:0] rampCnt_ff;
	logic [RPW-1:0] nxt_rampCnt;
	logic           rampStep_ff;
	logic           nxt_rampStep;
	logic [RPW-1:0] rampLast;
	logic [RPW-1:0] stepGap_ff;
	logic           gapValid_ff;

	always_comb begin
		rampLast     = shadowRamp_ff ? RPW'(RAMP_SLOW_CYC - 1) : RPW'(RAMP_FAST_CYC - 1);
		nxt_rampStep = 1'b0;
		nxt_rampCnt  = rampCnt_ff + 1'b1;
		if (state_ff == ST_LOAD || state_ff == ST_COLD) begin
			nxt_rampCnt = '0;
		end else if (rampCnt_ff >= rampLast) begin
			nxt_rampCnt  = '0;
			nxt_rampStep = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rampCnt_ff  <= '0;
			rampStep_ff <= 1'b0;
		end else begin
			rampCnt_ff  <= nxt_rampCnt;
			rampStep_ff <= nxt_rampStep;
		end
	end

	// Checking aid: cycles since the previous step, valid only between two steps
	always_ff @(posedge clk) begin
		if (!rst_n || state_ff == ST_LOAD || state_ff == ST_COLD) begin
			stepGap_ff  <= '0;
			gapValid_ff <= 1'b0;
		end else if (rampStep_ff) begin
			stepGap_ff  <= '0;
			gapValid_ff <= 1'b1;
		end else begin
			stepGap_ff <= stepGap_ff + 1'b1;
		end
	end

	a_ramp_period: assert property (@(posedge clk) disable iff (!rst_n)
		rampStep_ff && gapValid_ff |-> stepGap_ff == rampLast)
		else $error("buck step period wrong");

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign addrCfgRdData = addrCfg_ff;
	assign targetAddr    = targetAddr_ff;
	assign deviceOn      = deviceOn_ff;
	assign seqDone       = seqDone_ff;
	assign regEnable     = regEnable_ff;
	assign regVoltage    = shadowVolt_ff;
	assign rampStep      = rampStep_ff;
	assign procResetOut  = 1'b0;
	assign procResetOe_n = resetOe_n_ff;
endmodule : pmic_otp_config_startup

/* verif/host_button_model.sv */
// Far-side model: power button on the request pin and host writes to the address register
module host_button_model (
	// Clock
	input  wire logic       clk,
	// Pin and register write
	output logic            pinLevel,
	output logic            wrDone,
	output logic [7:0]      wrData
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		pinLevel = 1'b0;
		wrDone   = 1'b0;
		wrData   = 8'h00;
	end

	// Pin moves off the sampling edge, like a slow mechanical contact
	task automatic set_pin(input logic lvl);
		@(negedge clk);
		pinLevel = lvl;
	endtask : set_pin

	// One-cycle write; software sets bit 7 itself to stay at the factory address
	task automatic write_addr(input logic [7:0] d);
		@(negedge clk);
		wrDone = 1'b1;
		wrData = d;
		@(negedge clk);
		wrDone = 1'b0;
		wrData = ~d;
	endtask : write_addr
endmodule : host_button_model

/* verif/pmic_otp_config_startup_tb_top.sv */
// Self-checking bench for the start-up configuration block
module pmic_otp_config_startup_tb_top
	import pmic_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Short counts keep the run brief
	localparam int LP = 50;
	localparam int SF = 10;
	localparam int SS = 40;
	localparam int RD = 20;

	logic        clk, rst_n, supOk, fMode, fRamp, fSpace;
	logic [7:0]  fAddr, swEn;
	logic [31:0] fSlot;
	logic [39:0] fVolt;
	wire logic   pin, wrDone, devOn, seqDone, rampStep, rstOut, rstOe_n;
	wire logic [7:0]  wrData, rdData, regEn;
	wire logic [6:0]  tAddr;
	wire logic [39:0] regV;
	// Open-drain reset line with pull-up
	wire logic   rstPin = rstOe_n ? 1'b1 : rstOut;
	int          fail_count, n_checks, cyc;

	////////////////////////////////////////////////////////////////////////////////
	pmic_otp_config_startup #(.LONG_PRESS_CYC(LP), .SLOT_FAST_CYC(SF), .SLOT_SLOW_CYC(SS),
		.RST_DELAY_CYC(RD)) pmic_otp_config_startup_inst (.clk(clk), .rst_n(rst_n),
		.powerRequestPin(pin), .supplyAboveUv(supOk), .fusePinMode(fMode), .fuseRampSel(fRamp),
		.fuseSlotSpacing(fSpace), .fuseAddrCfg(fAddr), .fuseSlotCode(fSlot), .fuseVolt(fVolt),
		.addrCfgWrDone(wrDone), .addrCfgWrData(wrData), .swRegEnable(swEn),
		.addrCfgRdData(rdData), .targetAddr(tAddr), .deviceOn(devOn), .seqDone(seqDone),
		.regEnable(regEn), .regVoltage(regV), .rampStep(rampStep), .procResetOut(rstOut),
		.procResetOe_n(rstOe_n));
	host_button_model host_button_model_inst (.clk(clk), .pinLevel(pin), .wrDone(wrDone),
		.wrData(wrData));

	initial clk = 1'b0;
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			$display("BAD %0t timeout", $time);
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("Checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	task automatic set_fuses(input logic [7:0] a, input logic [31:0] s, input logic [39:0] v, input logic r);
		fAddr = a;
		fSlot = s;
		fVolt = v;
		fRamp = r;
	endtask : set_fuses

	task automatic do_reset(input logic mode);
		@(negedge clk);
		rst_n = 1'b0;
		supOk = 1'b0;
		fMode = mode;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
	endtask : do_reset

	task automatic wait_en(input logic [7:0] e, output int t);
		int lim;
		lim = cyc + 400;
		while (regEn !== e && cyc < lim) @(negedge clk);
		t = cyc;
	endtask : wait_en

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_cold();
		chk({rdData, tAddr, rstPin, devOn}, {8'h08, 7'h08, 2'b00});
		chk(regV, 40'h00_0000_0000);
		supOk = 1'b1;
		repeat (3) @(negedge clk);
		chk(regV, fVolt);
		chk(tAddr, 7'h0B);
		chk(devOn, 1'b0);
	endtask : t_cold

	task automatic t_addr();
		for (int i = 0; i < 8; i++) begin
			host_button_model_inst.write_addr(8'h50 | 8'(i));
			chk(tAddr, 7'h08 | 7'(i));
			chk(rdData, 8'h08 | 8'(i));
			chk(tAddr[6:3], 4'h1);
		end
		host_button_model_inst.write_addr(8'h85);
		chk(tAddr, FACTORY_ADDR);
		chk(rdData, 8'h8D);
	endtask : t_addr

	// Slots 1, 2, 3 in use; of the code-0 regulators only regulator 2 is enabled by software
	task automatic t_seq(input logic sp, input int s, input int rp, input logic [6:0] ea);
		int t1, t2, t3, ta;
		fSpace = sp;
		swEn = 8'h04;
		host_button_model_inst.set_pin(1'b1);
		wait_en(8'h01, t1);
		chk(devOn, 1'b1);
		chk(regV, fVolt);
		chk(tAddr, ea);
		wait_en(8'h03, t2);
		chk(t2 - t1, s);
		wait_en(8'h0B, t3);
		chk(t3 - t2, s);
		chk({seqDone, rstPin}, 2'b00);
		while (rstPin !== 1'b1 && cyc < t3 + 100) @(negedge clk);
		chk(cyc - t3 >= RD && cyc - t3 <= RD + 1, 1'b1);
		repeat (2) @(negedge clk);
		chk({seqDone, regEn}, 9'h10F);
		while (rampStep !== 1'b1 && cyc < t3 + 500) @(negedge clk);
		ta = cyc;
		@(negedge clk);
		while (rampStep !== 1'b1 && cyc < t3 + 900) @(negedge clk);
		chk(cyc - ta, rp);
	endtask : t_seq

	task automatic t_off();
		host_button_model_inst.set_pin(1'b0);
		repeat (5) @(negedge clk);
		chk({devOn, seqDone, regEn, rstPin}, 11'h000);
	endtask : t_off

	task automatic t_edge();
		int t;
		host_button_model_inst.set_pin(1'b1);
		do_reset(PIN_MODE_EDGE);
		supOk = 1'b1;
		repeat (10) @(negedge clk);
		chk(devOn, 1'b0);
		host_button_model_inst.set_pin(1'b0);
		@(negedge clk);
		chk(devOn, 1'b0);
		repeat (4) @(negedge clk);
		chk(devOn, 1'b1);
		host_button_model_inst.set_pin(1'b1);
		repeat (5) @(negedge clk);
		host_button_model_inst.set_pin(1'b0);
		repeat (LP - 2) @(negedge clk);
		host_button_model_inst.set_pin(1'b1);
		repeat (6) @(negedge clk);
		chk(devOn, 1'b1);
		host_button_model_inst.set_pin(1'b0);
		t = cyc;
		while (devOn !== 1'b0 && cyc < t + LP + 10) @(negedge clk);
		chk(cyc - t >= LP + 1 && cyc - t <= LP + 3, 1'b1);
	endtask : t_edge

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		fail_count = 0;
		n_checks = 0;
		cyc = 0;
		rst_n = 1'b0;
		supOk = 1'b0;
		fMode = 1'b0;
		fSpace = 1'b0;
		set_fuses(8'h03, 32'h0000_3021, 40'h00_1234_5678, 1'b0);
		swEn = 8'h00;
		do_reset(PIN_MODE_LEVEL);
		t_cold();
		t_addr();
		t_seq(1'b0, SF, RAMP_FAST_CYC, 7'h0B);
		// New fuse values must stay hidden until the next turn-on
		set_fuses(8'h86, 32'h0000_3021, 40'h00_8765_4321, 1'b1);
		repeat (3) @(negedge clk);
		chk(regV, 40'h00_1234_5678);
		chk(tAddr, 7'h0B);
		t_off();
		t_seq(1'b1, SS, RAMP_SLOW_CYC, FACTORY_ADDR);
		t_off();
		t_edge();
		close_out();
	end
endmodule : pmic_otp_config_startup_tb_top
